// ---- src/cidr_pkg.sv ----
package cidr_pkg;

  // Relocatable configuration base; the data port sits one address above
  localparam logic [15:0] CFG_BASE_DEFAULT = 16'h03f0;
  localparam logic [15:0] DATA_PORT_OFFSET = 16'h0001;

  // Chip-level indices
  localparam logic [7:0] IDX_SOFT_RESET = 8'h02;
  localparam logic [7:0] IDX_RUN_ACCESS = 8'h03;
  localparam logic [7:0] IDX_BANK_SEL = 8'h07;
  localparam logic [7:0] IDX_GLOBAL_POWER = 8'h22;
  localparam logic [7:0] IDX_GLOBAL_TOP = 8'h2f;

  // Per-unit indices
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_BASE_HI = 8'h60;
  localparam logic [7:0] IDX_BASE_LO = 8'h61;
  localparam logic [7:0] IDX_IRQ_SEL = 8'h70;
  localparam logic [7:0] IDX_SLEEP_WAKE = 8'hf0;
  localparam logic [7:0] IDX_WD_CTRL = 8'hf4;
  localparam logic [7:0] IDX_SOFT_POWER_FIRST = 8'hb0;
  localparam logic [7:0] IDX_SOFT_POWER_LAST = 8'hb3;
  localparam logic [7:0] IDX_PORT1 = 8'hf6;
  localparam logic [7:0] IDX_PORT5 = 8'hf9;
  localparam logic [7:0] IDX_PORT6 = 8'hfa;

  // Run-mode selection register index, chosen by the low two bits
  localparam logic [3:0][7:0] RUN_SEL_INDEX = {8'hea, 8'he4, 8'he2, 8'he0};

  // Fields
  localparam int SOFT_RESET_BIT = 0;
  localparam int RUN_ENABLE_BIT = 7;
  localparam logic [7:0] RUN_ACCESS_MASK = 8'h83;
  localparam logic [7:0] RUN_ACCESS_RESET = 8'h03;
  localparam logic [7:0] BANK_SEL_RESET = 8'h00;
  localparam logic [7:0] GLOBAL_POWER_MASK = 8'h19;
  localparam int POWER_STANDBY_BIT = 5;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam int ACTIVATE_BIT = 0;

  // Watchdog control: bits 1,3 stored, bit 0 read-only status, bit 2 write-only trigger
  localparam logic [7:0] WD_CTRL_STORE_MASK = 8'h0a;
  localparam int WD_CTRL_STATUS_BIT = 0;
  localparam int WD_CTRL_TRIGGER_BIT = 2;
  localparam int NUM_WD = 3;
  localparam logic [2:0][7:0] WD_INDEX = {8'hf3, 8'hf2, 8'hf1};

  // Battery-backed auxiliary registers: index and battery power-on value
  localparam int NUM_BATT = 8;
  localparam logic [7:0][7:0] BATT_INDEX =
    {8'hfa, 8'hf9, 8'hf6, 8'hf0, 8'hef, 8'he7, 8'he6, 8'he5};
  localparam logic [7:0][7:0] BATT_RESET =
    {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00};

  // Logical units
  localparam int NUM_UNITS = 8;
  localparam logic [7:0] AUX_UNIT = 8'h08;
  localparam logic [7:0] ACPI_UNIT = 8'h0a;
  localparam int ACPI_SLOT = 7;
  localparam logic [7:0][7:0] UNIT_NUMBERS =
    {8'h0a, 8'h08, 8'h07, 8'h06, 8'h05, 8'h04, 8'h03, 8'h00};

endpackage

// ---- src/cidr_access_if.sv ----
`timescale 1ns/1ns
`default_nettype none
// Index/data strobes between the host port decoder and the register file
interface cidr_access_if;
  logic port_enable;
  logic index_wr;
  logic index_rd;
  logic data_wr;
  logic data_rd;
  logic [7:0] index;
  logic [7:0] wdata;
  modport port (input port_enable, output index_wr, index_rd, data_wr, data_rd, index, wdata);
  modport regs (output port_enable, input index_wr, index_rd, data_wr, data_rd, index, wdata);
endinterface
`default_nettype wire

// ---- src/cidr_host_port.sv ----
`timescale 1ns/1ns
`default_nettype none
module cidr_host_port #(
  parameter logic [15:0] CONFIG_BASE = cidr_pkg::CFG_BASE_DEFAULT
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [15:0] io_addr_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [7:0] io_wdata_in,
  cidr_access_if.port acc
);
  logic [7:0] index_reg;
  logic hit_index;
  logic hit_data;

  // Data port immediately follows the index port
  assign hit_index = io_addr_in == CONFIG_BASE;
  assign hit_data = io_addr_in == 16'(CONFIG_BASE + cidr_pkg::DATA_PORT_OFFSET);

  // Strobes only while the register file opens the ports
  assign acc.index_wr = io_wr_in && hit_index && acc.port_enable;
  assign acc.index_rd = io_rd_in && hit_index && acc.port_enable;
  assign acc.data_wr = io_wr_in && hit_data && acc.port_enable;
  assign acc.data_rd = io_rd_in && hit_data && acc.port_enable;
  assign acc.index = index_reg;
  assign acc.wdata = io_wdata_in;

  // All eight bits kept, so no upper index aliases a lower one
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      index_reg <= cidr_pkg::ZERO_BYTE;
    else if (acc.index_wr)
      index_reg <= io_wdata_in;
  end

  a_index_full: assert property (@(posedge clk_in) disable iff (rst_in)
    acc.index_wr |=> index_reg == $past(io_wdata_in))
    else $error("index port lost bits");
endmodule
`default_nettype wire

// ---- src/cidr_activate_bank.sv ----
`timescale 1ns/1ns
`default_nettype none
module cidr_activate_bank #(
  parameter int UNITS = cidr_pkg::NUM_UNITS
) (
  input wire logic clk_in,
  input wire logic clr_in,
  input wire logic wr_in,
  input wire logic [7:0] unit_in,
  input wire logic wdata_in,
  output logic [UNITS-1:0] active_out
);
  // One activate flop per unit, written only when its bank is selected
  for (genvar i = 0; i < UNITS; i++)
  begin : g_unit
    always_ff @(posedge clk_in)
    begin
      if (clr_in)
        active_out[i] <= 1'b0;
      else if (wr_in && unit_in == cidr_pkg::UNIT_NUMBERS[i])
        active_out[i] <= wdata_in;
    end

    a_other_unit: assert property (@(posedge clk_in) disable iff (clr_in)
      wr_in && unit_in != cidr_pkg::UNIT_NUMBERS[i] |=> $stable(active_out[i]))
      else $error("activate reached an unselected unit");
  end
endmodule
`default_nettype wire

// ---- src/cidr_config_regs.sv ----
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - All eight index bits select a register; no upper-bit aliasing.
// - Unimplemented registers and bits ignore writes and read as zero.
// - Host writes the index first; data port reaches the indexed register.
// - Chip-level registers below 0x30 respond only in configuration mode.
// - Writing one to bit 0 at 0x02 soft-resets; the bit self-clears.
// - Run-access bit 7 opens port, watchdog control and soft-power registers outside config.
// - Bits 1:0 pick run-mode selection index 0xE0/E2/E4/EA; reset 0x03.
// - Bank select at 0x07 chooses the unit bank above 0x30; resets zero.
// - Activate writes change only the currently selected unit.
// - Base pair: lower index high byte, next index low byte.
// - Power-management activate never gates its system control interrupt.
// - Battery-backed registers survive hard, main and soft reset.
// - Global power bit 5 resets only on standby-supply power-on.
// - Watchdog control mixes read-only and write-only bits.
// - Eight logical units, each with its own bank, chosen by bank select.
// - Unit registers from 0x30 upward need configuration mode unless run-access bit 7 opens them.
module cidr_config_regs #(
  parameter logic [15:0] CONFIG_BASE = cidr_pkg::CFG_BASE_DEFAULT
) (
  input wire logic CLOCK_IN,
  input wire logic RESET_IN,
  input wire logic HARD_RESET_IN,
  input wire logic VCC_POR_IN,
  input wire logic VTR_POR_IN,
  input wire logic CONFIG_MODE_IN,
  input wire logic [15:0] IO_ADDR_IN,
  input wire logic IO_WR_IN,
  input wire logic IO_RD_IN,
  input wire logic [7:0] IO_WDATA_IN,
  input wire logic WDOG_EXPIRED_IN,
  input wire logic SCI_EVENT_IN,
  output logic [7:0] IO_RDATA_OUT,
  output logic IO_RDATA_VALID_OUT,
  output logic SOFT_RESET_OUT,
  output logic [7:0] LOGICAL_BANK_OUT,
  output logic [7:0] UNIT_ACTIVE_OUT,
  output logic [7:0] GLOBAL_POWER_OUT,
  output logic [15:0] ACPI_BASE_OUT,
  output logic [7:0] ACPI_IRQ_SELECT_OUT,
  output logic SYSTEM_CONTROL_INTERRUPT_OUT,
  output logic WDOG_TRIGGER_OUT
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  cidr_access_if acc ();

  logic soft_reset_reg;
  logic [7:0] run_access_reg;
  logic [7:0] bank_sel_reg;
  logic [7:0] power_main_reg;
  logic power_standby_reg;
  logic [7:0] acpi_base_hi_reg;
  logic [7:0] acpi_base_lo_reg;
  logic [7:0] acpi_irq_reg;
  logic [7:0] sleep_wake_reg;
  logic [7:0] batt_reg [cidr_pkg::NUM_BATT];
  logic [7:0] wd_reg [cidr_pkg::NUM_WD];
  logic [7:0] wd_ctrl_reg;
  logic wd_status_reg;
  logic wd_trigger_reg;
  logic sci_reg;
  logic [7:0] rdata_reg;
  logic rvalid_reg;

  logic hard_rst;
  logic standby_rst;
  logic unit_rst;
  logic [7:0] cur_index;
  logic [7:0] cur_unit;
  logic [7:0] run_sel_index;
  logic run_open;
  logic run_target;
  logic access_ok;
  logic wr;
  logic global_wr;
  logic aux_sel;
  logic acpi_sel;
  logic [7:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset classes

  // Battery power-on (RESET_IN) implies every lower class
  assign hard_rst = RESET_IN || HARD_RESET_IN || VCC_POR_IN;
  assign standby_rst = RESET_IN || VTR_POR_IN;
  assign unit_rst = hard_rst || VTR_POR_IN;

  ////////////////////////////////////////////////////////////////////////////////
  // Host port and access gating

  cidr_host_port #(
    .CONFIG_BASE(CONFIG_BASE)
  ) u_host_port (
    .clk_in(CLOCK_IN),
    .rst_in(RESET_IN),
    .io_addr_in(IO_ADDR_IN),
    .io_wr_in(IO_WR_IN),
    .io_rd_in(IO_RD_IN),
    .io_wdata_in(IO_WDATA_IN),
    .acc(acc.port)
  );

  // Run-mode selection index from the low two bits
  assign run_sel_index = cidr_pkg::RUN_SEL_INDEX[run_access_reg[1:0]];
  assign run_open = run_access_reg[cidr_pkg::RUN_ENABLE_BIT];
  assign cur_index = acc.index;

  // Registers reachable in run mode, all in the auxiliary bank
  assign run_target = cur_index == cidr_pkg::IDX_PORT1
    || cur_index == cidr_pkg::IDX_PORT5
    || cur_index == cidr_pkg::IDX_PORT6
    || cur_index == cidr_pkg::IDX_WD_CTRL
    || cur_index == run_sel_index
    || (cur_index >= cidr_pkg::IDX_SOFT_POWER_FIRST
        && cur_index <= cidr_pkg::IDX_SOFT_POWER_LAST);

  // Ports open in config mode, or in run mode when enabled
  assign acc.port_enable = CONFIG_MODE_IN || run_open;
  assign access_ok = CONFIG_MODE_IN || (run_open && run_target);

  // Run mode always lands in the auxiliary bank, whatever bank is selected
  assign cur_unit = CONFIG_MODE_IN ? bank_sel_reg : cidr_pkg::AUX_UNIT;
  assign aux_sel = cur_unit == cidr_pkg::AUX_UNIT;
  assign acpi_sel = cur_unit == cidr_pkg::ACPI_UNIT;
  assign wr = acc.data_wr && access_ok;
  assign global_wr = wr && CONFIG_MODE_IN && cur_index <= cidr_pkg::IDX_GLOBAL_TOP;

  ////////////////////////////////////////////////////////////////////////////////
  // Chip-level registers

  // Soft reset strobe; lasts one cycle, so software never clears it
  always_ff @(posedge CLOCK_IN)
  begin
    if (hard_rst)
      soft_reset_reg <= 1'b0;
    else
      soft_reset_reg <= global_wr && cur_index == cidr_pkg::IDX_SOFT_RESET
        && acc.wdata[cidr_pkg::SOFT_RESET_BIT];
  end

  // Run-mode access select; reserved bits 6:2 never stored
  always_ff @(posedge CLOCK_IN)
  begin
    if (hard_rst)
      run_access_reg <= cidr_pkg::RUN_ACCESS_RESET;
    else if (global_wr && cur_index == cidr_pkg::IDX_RUN_ACCESS)
      run_access_reg <= acc.wdata & cidr_pkg::RUN_ACCESS_MASK;
  end

  // Logical bank select, cleared by soft reset too
  always_ff @(posedge CLOCK_IN)
  begin
    if (hard_rst || soft_reset_reg)
      bank_sel_reg <= cidr_pkg::BANK_SEL_RESET;
    else if (global_wr && cur_index == cidr_pkg::IDX_BANK_SEL)
      bank_sel_reg <= acc.wdata;
  end

  // Global power bits other than the standby-held one
  always_ff @(posedge CLOCK_IN)
  begin
    if (hard_rst)
      power_main_reg <= cidr_pkg::ZERO_BYTE;
    else if (global_wr && cur_index == cidr_pkg::IDX_GLOBAL_POWER)
      power_main_reg <= acc.wdata & cidr_pkg::GLOBAL_POWER_MASK;
  end

  // Standby bit: hard reset and main power-on leave it alone
  always_ff @(posedge CLOCK_IN)
  begin
    if (standby_rst)
      power_standby_reg <= 1'b0;
    else if (global_wr && cur_index == cidr_pkg::IDX_GLOBAL_POWER)
      power_standby_reg <= acc.wdata[cidr_pkg::POWER_STANDBY_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-unit registers

  cidr_activate_bank #(
    .UNITS(cidr_pkg::NUM_UNITS)
  ) u_activate (
    .clk_in(CLOCK_IN),
    .clr_in(unit_rst || soft_reset_reg),
    .wr_in(wr && cur_index == cidr_pkg::IDX_ACTIVATE),
    .unit_in(cur_unit),
    .wdata_in(acc.wdata[cidr_pkg::ACTIVATE_BIT]),
    .active_out(UNIT_ACTIVE_OUT)
  );

  // Power-management base pair, high byte at the lower index
  always_ff @(posedge CLOCK_IN)
  begin
    if (unit_rst || soft_reset_reg)
    begin
      acpi_base_hi_reg <= cidr_pkg::ZERO_BYTE;
      acpi_base_lo_reg <= cidr_pkg::ZERO_BYTE;
    end
    else if (wr && acpi_sel && cur_index == cidr_pkg::IDX_BASE_HI)
      acpi_base_hi_reg <= acc.wdata;
    else if (wr && acpi_sel && cur_index == cidr_pkg::IDX_BASE_LO)
      acpi_base_lo_reg <= acc.wdata;
  end

  // Battery-backed power-management registers
  always_ff @(posedge CLOCK_IN)
  begin
    if (RESET_IN)
    begin
      acpi_irq_reg <= cidr_pkg::ZERO_BYTE;
      sleep_wake_reg <= cidr_pkg::ZERO_BYTE;
    end
    else if (wr && acpi_sel && cur_index == cidr_pkg::IDX_IRQ_SEL)
      acpi_irq_reg <= acc.wdata;
    else if (wr && acpi_sel && cur_index == cidr_pkg::IDX_SLEEP_WAKE)
      sleep_wake_reg <= acc.wdata;
  end

  // Battery-backed auxiliary pin and port registers
  for (genvar i = 0; i < cidr_pkg::NUM_BATT; i++)
  begin : g_batt
    always_ff @(posedge CLOCK_IN)
    begin
      if (RESET_IN)
        batt_reg[i] <= cidr_pkg::BATT_RESET[i];
      else if (wr && aux_sel && cur_index == cidr_pkg::BATT_INDEX[i])
        batt_reg[i] <= acc.wdata;
    end
  end

  // Watchdog units, value and configuration; soft reset has no effect
  for (genvar i = 0; i < cidr_pkg::NUM_WD; i++)
  begin : g_wd
    always_ff @(posedge CLOCK_IN)
    begin
      if (unit_rst)
        wd_reg[i] <= cidr_pkg::ZERO_BYTE;
      else if (wr && aux_sel && cur_index == cidr_pkg::WD_INDEX[i])
        wd_reg[i] <= acc.wdata;
    end
  end

  // Watchdog control: stored bits, write-only trigger pulse, read-only status
  always_ff @(posedge CLOCK_IN)
  begin
    if (unit_rst)
    begin
      wd_ctrl_reg <= cidr_pkg::ZERO_BYTE;
      wd_trigger_reg <= 1'b0;
    end
    else
    begin
      wd_trigger_reg <= wr && aux_sel && cur_index == cidr_pkg::IDX_WD_CTRL
        && acc.wdata[cidr_pkg::WD_CTRL_TRIGGER_BIT];
      if (wr && aux_sel && cur_index == cidr_pkg::IDX_WD_CTRL)
        wd_ctrl_reg <= acc.wdata & cidr_pkg::WD_CTRL_STORE_MASK;
    end
  end

  // Expiry level from the watchdog counter, same clock
  always_ff @(posedge CLOCK_IN)
  begin
    if (unit_rst)
      wd_status_reg <= 1'b0;
    else
      wd_status_reg <= WDOG_EXPIRED_IN;
  end

  // Interrupt passes whatever the activate bit says
  always_ff @(posedge CLOCK_IN)
  begin
    if (RESET_IN)
      sci_reg <= 1'b0;
    else
      sci_reg <= SCI_EVENT_IN;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path

  // Anything not matched, or not reachable now, reads as zero
  always_comb
  begin
    rd_mux = cidr_pkg::ZERO_BYTE;
    if (CONFIG_MODE_IN && cur_index == cidr_pkg::IDX_RUN_ACCESS)
      rd_mux = run_access_reg;
    else if (CONFIG_MODE_IN && cur_index == cidr_pkg::IDX_BANK_SEL)
      rd_mux = bank_sel_reg;
    else if (CONFIG_MODE_IN && cur_index == cidr_pkg::IDX_GLOBAL_POWER)
    begin
      rd_mux = power_main_reg;
      rd_mux[cidr_pkg::POWER_STANDBY_BIT] = power_standby_reg;
    end
    else if (cur_index == cidr_pkg::IDX_ACTIVATE)
    begin
      for (int u = 0; u < cidr_pkg::NUM_UNITS; u++)
        if (cur_unit == cidr_pkg::UNIT_NUMBERS[u])
          rd_mux[cidr_pkg::ACTIVATE_BIT] = UNIT_ACTIVE_OUT[u];
    end
    else if (acpi_sel)
    begin
      case (cur_index)
        cidr_pkg::IDX_BASE_HI: rd_mux = acpi_base_hi_reg;
        cidr_pkg::IDX_BASE_LO: rd_mux = acpi_base_lo_reg;
        cidr_pkg::IDX_IRQ_SEL: rd_mux = acpi_irq_reg;
        cidr_pkg::IDX_SLEEP_WAKE: rd_mux = sleep_wake_reg;
        default: rd_mux = cidr_pkg::ZERO_BYTE;
      endcase
    end
    else if (aux_sel)
    begin
      for (int b = 0; b < cidr_pkg::NUM_BATT; b++)
        if (cur_index == cidr_pkg::BATT_INDEX[b])
          rd_mux = batt_reg[b];
      for (int w = 0; w < cidr_pkg::NUM_WD; w++)
        if (cur_index == cidr_pkg::WD_INDEX[w])
          rd_mux = wd_reg[w];
      if (cur_index == cidr_pkg::IDX_WD_CTRL)
      begin
        rd_mux = wd_ctrl_reg;
        rd_mux[cidr_pkg::WD_CTRL_STATUS_BIT] = wd_status_reg;
      end
    end
  end

  // Answer one cycle after the strobe; blocked data reads return zero
  always_ff @(posedge CLOCK_IN)
  begin
    if (RESET_IN)
    begin
      rdata_reg <= cidr_pkg::ZERO_BYTE;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rvalid_reg <= acc.index_rd || acc.data_rd;
      if (acc.index_rd)
        rdata_reg <= cur_index;
      else if (acc.data_rd)
        rdata_reg <= access_ok ? rd_mux : cidr_pkg::ZERO_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign IO_RDATA_OUT = rdata_reg;
  assign IO_RDATA_VALID_OUT = rvalid_reg;
  assign SOFT_RESET_OUT = soft_reset_reg;
  assign LOGICAL_BANK_OUT = bank_sel_reg;
  assign GLOBAL_POWER_OUT = {power_main_reg[7:6], power_standby_reg, power_main_reg[4:0]};
  assign ACPI_BASE_OUT = {acpi_base_hi_reg, acpi_base_lo_reg};
  assign ACPI_IRQ_SELECT_OUT = acpi_irq_reg;
  assign SYSTEM_CONTROL_INTERRUPT_OUT = sci_reg;
  assign WDOG_TRIGGER_OUT = wd_trigger_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (RESET_IN);

  a_soft_self_clear: assert property (
    !hard_rst && global_wr && cur_index == cidr_pkg::IDX_SOFT_RESET && acc.wdata[0]
    |=> soft_reset_reg ##1 !soft_reset_reg)
    else $error("soft reset not a single pulse");

  a_global_locked: assert property (
    acc.data_wr && !CONFIG_MODE_IN && !hard_rst && !soft_reset_reg
    |=> $stable(bank_sel_reg) && $stable(run_access_reg))
    else $error("chip-level register written outside config mode");

  a_reserved_zero: assert property (
    acc.data_rd && cur_index > cidr_pkg::IDX_BANK_SEL && cur_index < 8'h20
    |=> IO_RDATA_VALID_OUT && IO_RDATA_OUT == 8'h00)
    else $error("reserved index read nonzero");

  a_run_blocked: assert property (
    !CONFIG_MODE_IN && !run_open |-> !acc.data_wr && !acc.data_rd)
    else $error("data port open in run mode while disabled");

  a_base_high_first: assert property (
    wr && acpi_sel && cur_index == cidr_pkg::IDX_BASE_HI && !unit_rst && !soft_reset_reg
    |=> ACPI_BASE_OUT[15:8] == $past(acc.wdata) && $stable(ACPI_BASE_OUT[7:0]))
    else $error("base high byte misplaced");

  a_battery_keep: assert property (
    (HARD_RESET_IN || VCC_POR_IN || soft_reset_reg) && !wr
    |=> $stable(batt_reg[5]) && $stable(acpi_irq_reg))
    else $error("battery register lost on lesser reset");

  a_standby_bit: assert property (
    VCC_POR_IN && !VTR_POR_IN && !global_wr |=> $stable(power_standby_reg))
    else $error("standby power bit cleared by main reset");

  a_sci_ungated: assert property (
    SCI_EVENT_IN && !UNIT_ACTIVE_OUT[cidr_pkg::ACPI_SLOT] |=> SYSTEM_CONTROL_INTERRUPT_OUT)
    else $error("interrupt gated by activate");

  a_wdog_soft: assert property (
    soft_reset_reg && !unit_rst && !wr |=> $stable(wd_reg[0]) && $stable(wd_ctrl_reg))
    else $error("watchdog register hit by soft reset");

  a_bank_readback: assert property (
    acc.data_rd && CONFIG_MODE_IN && cur_index == cidr_pkg::IDX_BANK_SEL
    |=> IO_RDATA_OUT == $past(bank_sel_reg))
    else $error("bank select read wrong register");

endmodule
`default_nettype wire

// ---- bench/cidr_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// Host side of the index/data ports, one strobe per cycle
module cidr_host_model #(
  parameter logic [15:0] BASE = 16'h03f0
) (
  input wire logic clk_in,
  output logic [15:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] wdata_out
);
  initial
  begin
    {addr_out, wr_out, rd_out, wdata_out} = '0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Index cycle always first, data cycle right behind it
  task automatic cycle(input logic [7:0] idx, input logic rd, input logic [7:0] data);
    @(posedge clk_in);
    addr_out <= BASE;
    wr_out <= 1'b1;
    wdata_out <= idx;
    @(posedge clk_in);
    addr_out <= BASE + 16'h0001;
    wr_out <= ~rd;
    rd_out <= rd;
    wdata_out <= data;
    @(posedge clk_in);
    // Idle lines flip so a stale value never looks like a cycle
    wr_out <= 1'b0;
    rd_out <= 1'b0;
    addr_out <= ~addr_out;
    wdata_out <= ~wdata_out;
  endtask
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst, hard, vcc, vtr, cfg, wdog, system_control_interrupt, io_wr, io_rd, valid, srst, sci_out, trig;
  logic [15:0] addr, base16;
  logic [7:0] wdata, rdata, bank, active, power, irqsel, v, hi, lo;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h6c19;
  int num_errors = 0;
  int n_checks = 0;
  // Clock at 100 MHz
  always #5 clk = ~clk;
  cidr_config_regs dut_u (.CLOCK_IN(clk), .RESET_IN(rst), .HARD_RESET_IN(hard),
    .VCC_POR_IN(vcc), .VTR_POR_IN(vtr), .CONFIG_MODE_IN(cfg), .IO_ADDR_IN(addr),
    .IO_WR_IN(io_wr), .IO_RD_IN(io_rd), .IO_WDATA_IN(wdata), .WDOG_EXPIRED_IN(wdog),
    .SCI_EVENT_IN(system_control_interrupt), .IO_RDATA_OUT(rdata), .IO_RDATA_VALID_OUT(valid),
    .SOFT_RESET_OUT(srst), .LOGICAL_BANK_OUT(bank), .UNIT_ACTIVE_OUT(active),
    .GLOBAL_POWER_OUT(power), .ACPI_BASE_OUT(base16), .ACPI_IRQ_SELECT_OUT(irqsel),
    .SYSTEM_CONTROL_INTERRUPT_OUT(sci_out), .WDOG_TRIGGER_OUT(trig));
  cidr_host_model #(.BASE(cidr_pkg::CFG_BASE_DEFAULT)) host_u (.clk_in(clk),
    .addr_out(addr), .wr_out(io_wr), .rd_out(io_rd), .wdata_out(wdata));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic put(input logic [7:0] i, input logic [7:0] d);
    host_u.cycle(i, 1'b0, d);
  endtask
  task automatic get(input logic [7:0] i, input logic [7:0] e);
    exp_q.push_back(e);
    host_u.cycle(i, 1'b1, 8'h00);
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Every answer must match the oldest noted read; an answer to nothing is a fault
  always @(posedge clk)
    if (valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk(16'h0001, 16'h0000);
      else
        chk({8'h00, rdata}, {8'h00, exp_q.pop_front()});
    end
  // Main sequence
  initial
  begin
    {rst, hard, vcc, vtr, cfg, wdog, system_control_interrupt} = 7'b1000100;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    get(8'h03, 8'h03);
    get(8'h07, 8'h00);
    put(8'h07, cidr_pkg::AUX_UNIT);
    get(8'he6, 8'h01);
    put(8'h05, 8'hff);
    get(8'h05, 8'h00);
    get(8'h1f, 8'h00);
    put(8'h03, 8'hff);
    get(8'h03, 8'h83);
    put(8'h87, 8'ha5);
    get(8'h07, cidr_pkg::AUX_UNIT);
    $display("Test reset values and decode done");
    for (int i = 0; i < 8; i++)
    begin
      put(8'h07, cidr_pkg::UNIT_NUMBERS[i]);
      put(8'h30, 8'h01);
      #1;
      chk({8'h00, active}, 16'((2 << i) - 1));
    end
    get(8'h30, 8'h01);
    hi = rnd();
    lo = rnd();
    v = rnd();
    put(8'h60, hi);
    put(8'h61, lo);
    put(8'h70, v);
    #1;
    chk(base16, {hi, lo});
    chk({8'h00, irqsel}, {8'h00, v});
    $display("Test unit banks done");
    put(8'h07, cidr_pkg::AUX_UNIT);
    put(8'hf6, v);
    put(8'hf1, 8'h33);
    put(8'h22, 8'hff);
    put(8'h02, 8'h01);
    #1;
    chk({15'h0000, srst}, 16'h0001);
    @(posedge clk);
    #1;
    chk({bank, active}, 16'h0000);
    chk(base16, 16'h0000);
    chk({8'h00, power}, 16'h0039);
    get(8'h02, 8'h00);
    get(8'h03, 8'h83);
    put(8'h07, cidr_pkg::AUX_UNIT);
    get(8'hf6, v);
    get(8'hf1, 8'h33);
    $display("Test soft reset done");
    wdog <= 1'b1;
    get(8'hf4, 8'h01);
    put(8'hf4, 8'hff);
    #1;
    chk({15'h0000, trig}, 16'h0001);
    get(8'hf4, 8'h0b);
    system_control_interrupt <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({15'h0000, sci_out}, 16'h0001);
    $display("Test watchdog and interrupt done");
    put(8'h03, 8'h80);
    cfg <= 1'b0;
    get(8'hf6, v);
    put(8'h07, 8'h00);
    get(8'h07, 8'h00);
    cfg <= 1'b1;
    put(8'h03, 8'h03);
    cfg <= 1'b0;
    host_u.cycle(8'hf6, 1'b1, 8'h00);
    put(8'h07, 8'h00);
    cfg <= 1'b1;
    get(8'h07, cidr_pkg::AUX_UNIT);
    $display("Test run mode done");
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clk);
      {hard, vcc, vtr} <= 3'b100 >> k;
      @(posedge clk);
      {hard, vcc, vtr} <= 3'b000;
      put(8'h07, cidr_pkg::AUX_UNIT);
      // Standby power-on clears only bit 5; hard and main keep only bit 5
      get(8'h22, (k < 2) ? 8'h20 : 8'h19);
      get(8'hf1, 8'h00);
      get(8'hf6, v);
      put(8'h22, 8'hff);
      put(8'hf1, 8'h33);
    end
    $display("Test reset domains done");
    for (int k = 0; k < 20 && exp_q.size() > 0; k++)
      @(posedge clk);
    chk(16'(exp_q.size()), 16'h0000);
    finish_test();
  end
endmodule
`default_nettype wire
